// ---- shared/sdcfg_params.svh ----
// register offsets, field positions, reset values and timing counts of the divider config bank
`ifndef SDCFG_PARAMS_SVH
`define SDCFG_PARAMS_SVH
`define SDCFG_OFS_INT 8'h00
`define SDCFG_OFS_FRAC 8'h04
`define SDCFG_OFS_STAT 8'h08
`define SDCFG_SEL_LSB 0
`define SDCFG_SEL_W 5
`define SDCFG_SEL_INT 5'h0a
`define SDCFG_SEL_FRAC 5'h0b
`define SDCFG_INTEGER_DIVIDE_VALUE_LSB 5
`define SDCFG_INTEGER_DIVIDE_VALUE_W 16
`define SDCFG_INTEGER_DIVIDE_VALUE_RST 16'h0080
`define SDCFG_PDIV_LSB 21
`define SDCFG_PDIV_RST 2'h1
`define SDCFG_PRSC_BIT 23
`define SDCFG_PRSC_RST 1'b1
`define SDCFG_CORE_LSB 26
`define SDCFG_CORE_RST 2'h2
`define SDCFG_SINGLE_BIT 28
`define SDCFG_ERRC_LSB 29
`define SDCFG_CAL_BIT 31
`define SDCFG_FRACTIONAL_DIVIDE_VALUE_LSB 5
`define SDCFG_FRACTIONAL_DIVIDE_VALUE_W 25
`define SDCFG_CAL_NS 6400
`define SDCFG_CLK_NS 100
`define SDCFG_CAL_CYC (`SDCFG_CAL_NS / `SDCFG_CLK_NS)
`endif

// ---- shared/sdcfg_pkg.sv ----
// types shared by the divider configuration bank
package sdcfg_pkg;
  // pre-prescaler select codes
  typedef enum logic [1:0] {SDCFG_PDIV1, SDCFG_PDIV2, SDCFG_PDIV4, SDCFG_PDIV_BAD} sdcfg_pdiv_t;
  // decoded settings handed to the synthesizer
  typedef struct packed {
    logic [15:0] integer_divide_value;
    logic [2:0] pre_divide_ratio;
    logic prescaler_modulus_select;
    logic [1:0] oscillator_core_select;
    logic single_core_calibration_mode;
    logic [3:0] calibration_core_mask;
    logic [1:0] calibration_error_count;
    logic [24:0] fractional_divide_value;
  } sdcfg_cfg_t;
endpackage : sdcfg_pkg

// ---- verilog/sdcfg_regs.sv ----
// divider and calibration configuration words behind an axi4-lite slave
//
// Summary of operation
// [RL1] bits 0..4 of the integer and fractional words read back their fixed register select codes
// [RL2] sixteen-bit integer divide value in bits 5..20, reset with bit 12 set
// [RL3] bits 21..22 choose pre-divide 1, 2 or 4; reset code 01
// [RL4] bit 23 picks 4/5 (0) or 8/9 (1) prescaler; reset 1
// [RL5] bits 26..27 pick one of four oscillator cores, 00 lowest
// [RL6] bit 28 enables single-core calibration mode, cleared at reset
// [RL7] single-core mode restricts calibration search to the selected core
// [RL8] host programs calibration error count bits 29..30 to 00
// [RL9] writing 1 to bit 31 starts calibration; bit clears by itself
// [RL10] 25-bit fractional divide value in bits 5..29, reset zero
// [RL11] host writes reserved bits as zero and avoids pre-divide code 11
`timescale 1ns/1ps
`include "sdcfg_params.svh"
module sdcfg_regs
  import sdcfg_pkg::*;
#(
  parameter int CAL_CYCLES = `SDCFG_CAL_CYC
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output sdcfg_cfg_t cfg,
  output logic cal_start,
  output logic cal_busy
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  // ==========================================================================
  // write channel capture
  // ==========================================================================
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;
  logic wr_int, wr_frac, wr_hit;

  // address and data are taken in either order; a pending response blocks both
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_int = wr_fire && (awaddr_q == `SDCFG_OFS_INT);
  assign wr_frac = wr_fire && (awaddr_q == `SDCFG_OFS_FRAC);
  // the status word is read-only, so a write to it is an error like any hole
  assign wr_hit = wr_int || wr_frac;

  // next state of the write side
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      awaddr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  // register the write side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================================
  // configuration storage
  // ==========================================================================
  logic [31:0] int_q, int_d;
  logic [31:0] frac_q, frac_d;
  logic [31:0] int_merged, frac_merged;
  logic [31:0] int_keep, frac_keep;
  logic [31:0] int_rst, frac_rst;

  // writable bits only; select code and reserved bits are never stored
  assign int_keep = 32'h7cff_ffe0;
  assign frac_keep = 32'h3fff_ffe0;

  // byte lanes merged with the old contents
  always_comb
  begin
    int_merged = int_q;
    frac_merged = frac_q;
    for (int i = 0; i < 4; i++)
    begin
      if (wstrb_q[i])
      begin
        int_merged[8*i +: 8] = wdata_q[8*i +: 8];
        frac_merged[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
  end

  // reset images of the two words
  always_comb
  begin
    int_rst = 32'h0000_0000;
    int_rst[`SDCFG_INTEGER_DIVIDE_VALUE_LSB +: `SDCFG_INTEGER_DIVIDE_VALUE_W] = `SDCFG_INTEGER_DIVIDE_VALUE_RST; // RL2
    int_rst[`SDCFG_PDIV_LSB +: 2] = `SDCFG_PDIV_RST; // RL3
    int_rst[`SDCFG_PRSC_BIT] = `SDCFG_PRSC_RST; // RL4
    int_rst[`SDCFG_CORE_LSB +: 2] = `SDCFG_CORE_RST; // RL5
    int_rst[`SDCFG_SINGLE_BIT] = 1'b0; // RL6
    frac_rst = 32'h0000_0000; // RL10
  end

  // next value of the stored words; the calibration bit is kept apart
  always_comb
  begin
    int_d = int_q;
    frac_d = frac_q;
    if (wr_int)
    begin
      int_d = int_merged & int_keep; // RL2
    end
    if (wr_frac)
    begin
      frac_d = frac_merged & frac_keep; // RL10
    end
  end

  // register the stored words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_q <= int_rst; // RL2 RL3 RL4 RL5 RL6
      frac_q <= frac_rst; // RL10
    end
    else
    begin
      int_q <= int_d;
      frac_q <= frac_d;
    end
  end

  // ==========================================================================
  // calibration trigger
  // ==========================================================================
  logic busy_q, busy_d;
  logic start_q, start_d;
  logic [15:0] cnt_q, cnt_d;
  logic cal_req;

  // a trigger is honoured only when its byte lane is written
  assign cal_req = wr_int && wstrb_q[3] && wdata_q[`SDCFG_CAL_BIT];

  // a trigger during a running calibration restarts the count, so the last
  // request always gets a full run; the bit drops back without any host write
  always_comb
  begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    start_d = 1'b0;
    if (cal_req)
    begin
      busy_d = 1'b1; // RL9
      cnt_d = 16'h0000;
      start_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (cnt_q == CAL_LAST)
      begin
        busy_d = 1'b0; // RL9
      end
      else
      begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // register the calibration state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      busy_q <= busy_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
    end
  end

  assign cal_start = start_q;
  assign cal_busy = busy_q;

  // ==========================================================================
  // decoded settings
  // ==========================================================================
  sdcfg_pdiv_t pdiv;
  sdcfg_cfg_t cfg_d, cfg_q;

  assign pdiv = sdcfg_pdiv_t'(int_q[`SDCFG_PDIV_LSB +: 2]);

  // decode the words into the settings the synthesizer uses
  always_comb
  begin
    cfg_d = '0;
    cfg_d.integer_divide_value = int_q[`SDCFG_INTEGER_DIVIDE_VALUE_LSB +: `SDCFG_INTEGER_DIVIDE_VALUE_W]; // RL2
    unique case (pdiv)
      SDCFG_PDIV1: cfg_d.pre_divide_ratio = 3'h1; // RL3
      SDCFG_PDIV2: cfg_d.pre_divide_ratio = 3'h2; // RL3
      SDCFG_PDIV4: cfg_d.pre_divide_ratio = 3'h4; // RL3
      SDCFG_PDIV_BAD: cfg_d.pre_divide_ratio = 3'h0; // RL11
    endcase
    cfg_d.prescaler_modulus_select = int_q[`SDCFG_PRSC_BIT]; // RL4
    cfg_d.oscillator_core_select = int_q[`SDCFG_CORE_LSB +: 2]; // RL5
    cfg_d.single_core_calibration_mode = int_q[`SDCFG_SINGLE_BIT]; // RL6
    // one core only in single mode, otherwise the search spans all four
    if (int_q[`SDCFG_SINGLE_BIT])
    begin
      cfg_d.calibration_core_mask = 4'h1 << int_q[`SDCFG_CORE_LSB +: 2]; // RL7
    end
    else
    begin
      cfg_d.calibration_core_mask = 4'hf; // RL7
    end
    cfg_d.calibration_error_count = int_q[`SDCFG_ERRC_LSB +: 2]; // RL8
    cfg_d.fractional_divide_value = frac_q[`SDCFG_FRACTIONAL_DIVIDE_VALUE_LSB +: `SDCFG_FRACTIONAL_DIVIDE_VALUE_W]; // RL10
  end

  // settings leave through flip-flops, one cycle behind the stored words
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg = cfg_q;

  // ==========================================================================
  // read channel
  // ==========================================================================
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [7:0] raddr;

  assign s_axi_arready = !rvalid_q;
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  // read mux; select codes are constants, reserved bits read zero
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (raddr)
        `SDCFG_OFS_INT:
        begin
          rdata_d = int_q;
          rdata_d[`SDCFG_SEL_LSB +: `SDCFG_SEL_W] = `SDCFG_SEL_INT; // RL1
          rdata_d[`SDCFG_CAL_BIT] = busy_q; // RL9
        end
        `SDCFG_OFS_FRAC:
        begin
          rdata_d = frac_q;
          rdata_d[`SDCFG_SEL_LSB +: `SDCFG_SEL_W] = `SDCFG_SEL_FRAC; // RL1
        end
        `SDCFG_OFS_STAT:
        begin
          rdata_d = {29'h0000_0000, pdiv == SDCFG_PDIV_BAD, start_q, busy_q};
        end
        default:
        begin
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  // register the read side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : sdcfg_regs

// ---- verif/sdcfg_regs_checker.sv ----
// port assertions for the divider config bank
`timescale 1ns/1ps
module sdcfg_regs_checker
  import sdcfg_pkg::*;
#(
  parameter int CAL_CYCLES = 64
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire sdcfg_cfg_t cfg,
  input wire logic cal_start,
  input wire logic cal_busy
);
  // ==========
  // helper and checks
  logic [7:0] busy_cnt_q;
  logic [7:0] busy_cnt_d;
  // busy cycles since the trigger; a stuck busy shows as overrun
  always_comb
  begin
    busy_cnt_d = cal_start ? 8'h01 : (cal_busy ? busy_cnt_q + 8'h01 : 8'h00);
  end
  always_ff @(posedge aclk)
  begin
    busy_cnt_q <= aresetn ? busy_cnt_d : 8'h00;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cal_pulse_a: assert property (cal_start |=> !cal_start)
    else $error("trigger pulse too long");
  cal_busy_a: assert property (cal_start |-> cal_busy)
    else $error("no busy at trigger");
  busy_len_a: assert property (cal_busy |-> busy_cnt_q < CAL_CYCLES)
    else $error("busy overrun");
  busy_end_a: assert property ($fell(cal_busy) |-> busy_cnt_q == CAL_CYCLES)
    else $error("busy too short");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  // settings leave through a flop, so they show the reset word one edge after release
  rst_cfg_a: assert property ($rose(aresetn) |=> cfg.integer_divide_value == 16'h0080
    && cfg.pre_divide_ratio == 3'h2 && cfg.prescaler_modulus_select
    && cfg.oscillator_core_select == 2'h2
    && !cfg.single_core_calibration_mode) else $error("bad reset settings");
  // the first cycle after release still shows the cleared settings flop
  core_mask_a: assert property ($past(aresetn) |-> cfg.calibration_core_mask ==
    (cfg.single_core_calibration_mode ? 4'h1 << cfg.oscillator_core_select : 4'hf))
    else $error("bad core mask");
  start_c: cover property (cal_start);
  stall_c: cover property (s_axi_bvalid && !s_axi_bready);
  single_c: cover property (cfg.single_core_calibration_mode);
endmodule : sdcfg_regs_checker

bind sdcfg_regs sdcfg_regs_checker #(.CAL_CYCLES(CAL_CYCLES)) chk (.aclk, .aresetn,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .cfg, .cal_start, .cal_busy);

// ---- verif/sdcfg_host.sv ----
// host model: axi4-lite master with a slow write-answer option
`timescale 1ns/1ps
module sdcfg_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ==========
  // bus cycles; released address and data lines show the inverse so stale data never matches
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input int lag, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do
    begin
      @(posedge aclk);
      n++;
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      s_axi_awaddr <= (s_axi_awvalid && !s_axi_awready) ? a : ~a;
      s_axi_wdata <= (s_axi_wvalid && !s_axi_wready) ? d : ~d;
      s_axi_bready <= !(s_axi_bvalid && s_axi_bready) && (s_axi_bready || n >= lag);
    end
    while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      s_axi_araddr <= (s_axi_arvalid && !s_axi_arready) ? a : ~a;
      s_axi_rready <= !s_axi_rvalid;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : sdcfg_host

// ---- verif/test_synth_divider_config_regs.sv ----
// self-checking bench for the divider config bank
`timescale 1ns/1ps
module test_synth_divider_config_regs
  import sdcfg_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, p, c;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cal_start, cal_busy, s, m;
  logic [15:0] n;
  logic [24:0] f;
  sdcfg_cfg_t cfg;
  int k, starts = 0, cyc = 0, err_count = 0, tests_run = 0;
  integer seed = 64;
  // ==========
  // design and host; short calibration keeps the run brief
  sdcfg_regs #(.CAL_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cfg, .cal_start, .cal_busy);
  sdcfg_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // clock, trigger count and hang guard
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    starts <= starts + int'(cal_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      conclude();
    end
  end
  function automatic logic [31:0] int_word(input logic [15:0] n, input logic [1:0] p,
    input logic m, input logic [1:0] c, input logic s);
    return {3'b000, s, c, 2'b00, m, p, n, 5'h0a};
  endfunction : int_word
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(8'h00, d, r);
    chk("int reset", 32'h08a0_100a, d);
    host.rd(8'h04, d, r);
    chk("frac reset", 32'h0000_000b, d);
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      n = (i == 0) ? 16'hffff : 16'($random(seed));
      f = (i == 0) ? 25'h1ff_ffff : 25'($random(seed));
      p = 2'(i % 3);
      c = 2'(i % 4);
      s = 1'($random(seed));
      m = 1'($random(seed));
      w = int_word(n, p, m, c, s);
      host.wr(8'h00, w, 4'hf, i % 4, r);
      host.wr(8'h04, {2'b00, f, 5'h0b}, 4'hf, 0, r);
      host.rd(8'h00, d, r);
      chk("int word", w, d);
      host.rd(8'h04, d, r);
      chk("frac word", {2'b00, f, 5'h0b}, d);
      chk("ratio", 32'(3'h1 << p), 32'(cfg.pre_divide_ratio));
      chk("mask", 32'(s ? 4'h1 << c : 4'hf), 32'(cfg.calibration_core_mask));
      chk("integer_divide_value", 32'(n), 32'(cfg.integer_divide_value));
      chk("frac", 32'(f), 32'(cfg.fractional_divide_value));
      chk("modulus", 32'(m), 32'(cfg.prescaler_modulus_select));
      chk("core", 32'(c), 32'(cfg.oscillator_core_select));
      chk("single", 32'(s), 32'(cfg.single_core_calibration_mode));
      chk("errcount", 32'h0, 32'(cfg.calibration_error_count));
    end
    $display("test fields done");
    k = starts;
    host.wr(8'h00, w | 32'h8000_0000, 4'h7, 0, r);
    repeat (2) @(posedge aclk);
    chk("no trigger", 32'(k), 32'(starts));
    host.wr(8'h00, w | 32'h8000_0000, 4'hf, 0, r);
    chk("busy", 32'h1, 32'(cal_busy));
    // status is read while the short calibration still runs
    host.rd(8'h08, d, r);
    chk("status", 32'h1, d);
    repeat (8) @(posedge aclk);
    host.rd(8'h00, d, r);
    chk("self clear", w, d);
    chk("starts", 32'(k + 1), 32'(starts));
    $display("test calibration done");
    host.wr(8'h10, 32'h0, 4'hf, 4, r);
    chk("bad write", 32'h2, 32'(r));
    host.rd(8'h0c, d, r);
    chk("bad read", 32'h2, 32'(r));
    $display("test unmapped done");
    // reset again in mid-run; the written words must fall back to their reset images
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(8'h00, d, r);
    chk("int rereset", 32'h08a0_100a, d);
    host.rd(8'h04, d, r);
    chk("frac rereset", 32'h0000_000b, d);
    chk("core reset", 32'h2, 32'(cfg.oscillator_core_select));
    chk("mask reset", 32'hf, 32'(cfg.calibration_core_mask));
    $display("test reset again done");
    conclude();
  end
endmodule : test_synth_divider_config_regs
